// File: rtl/obp_map.svh
// Purpose: named constants shared by both ends of the debug probe link
// Assumes: included by bare name; definitions only
// Notes: DR layouts are LSB first on the wire
`ifndef OBP_MAP_SVH
`define OBP_MAP_SVH

// --------------------------------------------------------------------------
// clocking
// --------------------------------------------------------------------------
`define OBP_CLK_NS 10
`define OBP_TCK_HALF_NS 80
`define OBP_TCK_HALF_CYC ((`OBP_TCK_HALF_NS + `OBP_CLK_NS - 1) / `OBP_CLK_NS)
`define OBP_TLR_BITS 5

// --------------------------------------------------------------------------
// scan geometry
// --------------------------------------------------------------------------
`define OBP_PC_W 16
`define OBP_IR_LEN 4
`define OBP_DR_LEN 20
`define OBP_CHAIN_IR_MAX 32
`define OBP_IR_HDR 4'h3
`define OBP_IR_HDR_LEN 4
`define OBP_DR_HDR 4'h1
`define OBP_DR_HDR_LEN 3
`define OBP_TAIL_LEN 2

// --------------------------------------------------------------------------
// instructions
// --------------------------------------------------------------------------
`define OBP_IR_CAPTURE 4'h1
`define OBP_IR_BYPASS 4'hF
`define OBP_IR_STATUS 4'h1
`define OBP_IR_PCREAD 4'h2
`define OBP_IR_CMPSET 4'h3
`define OBP_IR_START 4'h4

// --------------------------------------------------------------------------
// data register fields
// --------------------------------------------------------------------------
`define OBP_STOP_BIT 16
`define OBP_CMP_IDX_LO 16
`define OBP_CMP_IDX_HI 17
`define OBP_CMP_EN_BIT 18
`define OBP_NUM_CMP 4
`define OBP_RSVD_CMP 2'h0
`define OBP_USER_BAD_IDX 2'h3
`define OBP_SW_BREAK_EN 1'b1

`endif

// File: rtl/obp_pkg.sv
// Purpose: types shared by both ends of the debug probe link
// Assumes: constants come from obp_map.svh
// Notes: none
package obp_pkg;
  typedef enum logic [1:0] {cmd_set_bp, cmd_clr_bp, cmd_start} obp_cmd_type;
  typedef enum logic [1:0] {op_poll, op_pcread, op_cmpset, op_start} obp_op_type;
  typedef enum logic [2:0] {
    seq_reset, seq_idle, seq_ir_hdr, seq_ir_shift, seq_ir_tail,
    seq_dr_hdr, seq_dr_shift, seq_dr_tail
  } obp_seq_type;
  typedef enum logic [3:0] {
    tap_tlr, tap_rti, tap_sel_dr, tap_cap_dr, tap_sh_dr, tap_ex1_dr, tap_pau_dr,
    tap_ex2_dr, tap_upd_dr, tap_sel_ir, tap_cap_ir, tap_sh_ir, tap_ex1_ir,
    tap_pau_ir, tap_ex2_ir, tap_upd_ir
  } obp_tap_type;
endpackage

// File: rtl/obp_if.sv
// Purpose: four-wire test port plus reset lines between probe and target
// Assumes: system reset is open drain with a pull-up
// Notes: srst_n is the resolved wire level
`timescale 1ns/10ps
interface obp_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic trst_n;
  logic srst_o;
  logic srst_oe;
  logic srst_n;

  // pull-up wins when nobody drives low
  assign srst_n = srst_oe ? srst_o : 1'b1;

  modport probe (output tck, output tms, output tdi, output trst_n,
                 output srst_o, output srst_oe, input tdo);
  modport target (input tck, input tms, input tdi, input trst_n,
                  input srst_n, output tdo);
endinterface

// File: rtl/obp_probe.sv
// Purpose: probe end; drives the test port, polls for breaks, reads state
// Assumes: single target on the chain, i_clock at 100 MHz
// Notes: test clock made here by dividing i_clock
`timescale 1ns/10ps
`include "obp_map.svh"

module obp_probe (
  input wire logic i_clock,
  input wire logic i_rst_n,
  obp_if.probe link,
  input wire logic i_cmd_valid,
  input wire obp_pkg::obp_cmd_type i_cmd,
  input wire logic [1:0] i_bp_index,
  input wire logic [`OBP_PC_W-1:0] i_bp_addr,
  input wire logic i_tap_reset,
  input wire logic i_hold_reset,
  output logic o_cmd_ready,
  output logic o_stopped,
  output logic o_state_valid,
  output logic [`OBP_PC_W-1:0] o_state_pc
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic at_end(input logic [4:0] cnt, input logic [4:0] len);
    return cnt == len - 5'h01;
  endfunction

  localparam logic [7:0] HalfLast = 8'(`OBP_TCK_HALF_CYC - 1);
  localparam logic [3:0] IrHdr = `OBP_IR_HDR;
  localparam logic [3:0] DrHdr = `OBP_DR_HDR;

  logic [7:0] div;
  logic tck;
  logic fall;
  logic rise;
  logic tdo_meta;
  logic tdo_sync;
  obp_pkg::obp_seq_type seq;
  obp_pkg::obp_op_type op;
  obp_pkg::obp_op_type next_op;
  logic [4:0] cnt;
  logic [`OBP_IR_LEN-1:0] ir_tx;
  logic [`OBP_IR_LEN-1:0] next_ir;
  logic [`OBP_DR_LEN-1:0] dr_tx;
  logic [`OBP_DR_LEN-1:0] next_dr;
  logic [`OBP_DR_LEN-1:0] rx;
  logic dr_bit;
  logic tms;
  logic tdi;
  logic trst_n;
  logic srst_oe;
  logic stopped;
  logic need_read;
  logic go;
  logic done;
  logic [1:0] hw_idx;

  // --------------------------------------------------------------------------
  // test clock divider
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || div == HalfLast) begin
      div <= 8'h00;
    end else begin
      div <= div + 8'h01;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      tck <= 1'b0;
    end else if (div == HalfLast) begin
      tck <= ~tck;
    end
  end

  assign fall = (div == HalfLast) && tck;
  assign rise = (div == HalfLast) && !tck;

  // data-out comes from another party; two flops before use
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      tdo_meta <= 1'b0;
      tdo_sync <= 1'b0;
    end else begin
      tdo_meta <= link.tdo;
      tdo_sync <= tdo_meta;
    end
  end

  // --------------------------------------------------------------------------
  // operation choice
  // --------------------------------------------------------------------------
  assign hw_idx = i_bp_index + 2'h1; // user slots skip the reserved one
  assign o_cmd_ready = fall && (seq == obp_pkg::seq_idle) && !need_read && !i_tap_reset;
  assign go = fall && (seq == obp_pkg::seq_idle) && !i_tap_reset
              && (need_read || i_cmd_valid || !stopped);

  always_comb begin
    next_op = obp_pkg::op_poll;
    next_ir = `OBP_IR_STATUS;
    next_dr = '0;
    if (need_read) begin
      next_op = obp_pkg::op_pcread;
      next_ir = `OBP_IR_PCREAD;
    end else if (i_cmd_valid) begin
      case (i_cmd)
        obp_pkg::cmd_start: begin
          next_op = obp_pkg::op_start;
          next_ir = `OBP_IR_START;
        end
        default: begin
          if (i_bp_index != `OBP_USER_BAD_IDX) begin
            next_op = obp_pkg::op_cmpset;
            next_ir = `OBP_IR_CMPSET;
            next_dr = {1'b0, (i_cmd == obp_pkg::cmd_set_bp), hw_idx, i_bp_addr};
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // scan sequencer, bits change after the falling edge
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || i_tap_reset) begin
      seq <= obp_pkg::seq_reset;
      cnt <= 5'h00;
      tms <= 1'b1;
      tdi <= 1'b1;
      dr_bit <= 1'b0;
      op <= obp_pkg::op_poll;
      ir_tx <= `OBP_IR_BYPASS;
      dr_tx <= '0;
    end else if (fall) begin
      cnt <= cnt + 5'h01;
      dr_bit <= (seq == obp_pkg::seq_dr_shift);
      tdi <= 1'b1;
      case (seq)
        obp_pkg::seq_reset: begin
          tms <= 1'b1;
          if (at_end(cnt, 5'(`OBP_TLR_BITS))) begin
            seq <= obp_pkg::seq_idle;
            cnt <= 5'h00;
          end
        end
        obp_pkg::seq_idle: begin
          tms <= 1'b0;
          cnt <= 5'h00;
          if (go) begin
            seq <= obp_pkg::seq_ir_hdr;
            op <= next_op;
            ir_tx <= next_ir;
            dr_tx <= next_dr;
          end
        end
        obp_pkg::seq_ir_hdr: begin
          tms <= IrHdr[cnt[1:0]];
          if (at_end(cnt, 5'(`OBP_IR_HDR_LEN))) begin
            seq <= obp_pkg::seq_ir_shift;
            cnt <= 5'h00;
          end
        end
        obp_pkg::seq_ir_shift: begin
          tdi <= ir_tx[cnt[1:0]];
          tms <= at_end(cnt, 5'(`OBP_IR_LEN));
          if (at_end(cnt, 5'(`OBP_IR_LEN))) begin
            seq <= obp_pkg::seq_ir_tail;
            cnt <= 5'h00;
          end
        end
        obp_pkg::seq_ir_tail: begin
          tms <= (cnt == 5'h00);
          if (at_end(cnt, 5'(`OBP_TAIL_LEN))) begin
            seq <= obp_pkg::seq_dr_hdr;
            cnt <= 5'h00;
          end
        end
        obp_pkg::seq_dr_hdr: begin
          tms <= DrHdr[cnt[1:0]];
          if (at_end(cnt, 5'(`OBP_DR_HDR_LEN))) begin
            seq <= obp_pkg::seq_dr_shift;
            cnt <= 5'h00;
          end
        end
        obp_pkg::seq_dr_shift: begin
          tdi <= dr_tx[cnt];
          tms <= at_end(cnt, 5'(`OBP_DR_LEN));
          if (at_end(cnt, 5'(`OBP_DR_LEN))) begin
            seq <= obp_pkg::seq_dr_tail;
            cnt <= 5'h00;
          end
        end
        default: begin
          tms <= (cnt == 5'h00);
          if (at_end(cnt, 5'(`OBP_TAIL_LEN))) begin
            seq <= obp_pkg::seq_idle;
            cnt <= 5'h00;
          end
        end
      endcase
    end
  end

  // single target: chain pads are zero, well inside the chain limit
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rx <= '0;
    end else if (rise && dr_bit) begin
      rx <= {tdo_sync, rx[`OBP_DR_LEN-1:1]};
    end
  end

  // --------------------------------------------------------------------------
  // results
  // --------------------------------------------------------------------------
  assign done = fall && (seq == obp_pkg::seq_dr_tail) && at_end(cnt, 5'(`OBP_TAIL_LEN));

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      stopped <= 1'b0;
      need_read <= 1'b0;
      o_state_valid <= 1'b0;
      o_state_pc <= '0;
    end else begin
      o_state_valid <= 1'b0;
      if (go && need_read) begin
        need_read <= 1'b0;
      end
      if (done) begin
        case (op)
          obp_pkg::op_poll: begin
            if (rx[`OBP_STOP_BIT]) begin
              stopped <= 1'b1;
              need_read <= 1'b1;
            end
          end
          obp_pkg::op_pcread: begin
            o_state_pc <= rx[`OBP_PC_W-1:0];
            o_state_valid <= 1'b1;
          end
          obp_pkg::op_start: begin
            stopped <= 1'b0;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // reset lines
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      trst_n <= 1'b0;
      srst_oe <= 1'b0;
    end else begin
      trst_n <= (seq != obp_pkg::seq_reset);
      srst_oe <= i_hold_reset;
    end
  end

  assign link.tck = tck;
  assign link.tms = tms;
  assign link.tdi = tdi;
  assign link.trst_n = trst_n;
  assign link.srst_o = 1'b0; // only ever pulls low; released reads high
  assign link.srst_oe = srst_oe;
  assign o_stopped = stopped;

endmodule

// File: rtl/obp_target.sv
// Purpose: target end; test port controller and on-chip debug unit
// Assumes: link pins come from another domain and are synchronised
// Notes: halt only stops the core; peripherals are not touched
`timescale 1ns/10ps
`include "obp_map.svh"
module obp_target (
  input wire logic i_clock,
  input wire logic i_rst_n,
  obp_if.target link,
  input wire logic [`OBP_PC_W-1:0] i_pc,
  input wire logic i_break_fetch,
  input wire logic i_port_disable,
  output logic o_halt,
  output logic o_core_reset_n
);

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic tck_q;
  logic rise;
  logic fall;
  logic tap_en;
  obp_pkg::obp_tap_type tap;
  logic [`OBP_IR_LEN-1:0] ir;
  logic [`OBP_IR_LEN-1:0] ir_sh;
  logic [`OBP_DR_LEN-1:0] dr_sh;
  logic byp;
  logic tdo;
  logic upd;
  logic [`OBP_PC_W-1:0] cmp_addr [`OBP_NUM_CMP];
  logic [`OBP_NUM_CMP-1:0] cmp_en;
  logic hit;
  logic [`OBP_PC_W-1:0] halt_pc;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      pin_meta <= 5'h1F;
      pin_sync <= 5'h1F;
      tck_q <= 1'b0;
    end else begin
      pin_meta <= {link.srst_n, link.trst_n, link.tdi, link.tms, link.tck};
      pin_sync <= pin_meta;
      tck_q <= pin_sync[0];
    end
  end

  assign rise = pin_sync[0] && !tck_q;
  assign fall = !pin_sync[0] && tck_q;
  // while held in system reset firmware cannot keep the port disabled
  assign tap_en = !i_port_disable || !pin_sync[4];
  assign o_core_reset_n = pin_sync[4];

  // --------------------------------------------------------------------------
  // port controller
  // --------------------------------------------------------------------------
  function automatic obp_pkg::obp_tap_type next_tap(input obp_pkg::obp_tap_type s,
                                                    input logic m);
    case (s)
      obp_pkg::tap_tlr: return m ? obp_pkg::tap_tlr : obp_pkg::tap_rti;
      obp_pkg::tap_rti: return m ? obp_pkg::tap_sel_dr : obp_pkg::tap_rti;
      obp_pkg::tap_sel_dr: return m ? obp_pkg::tap_sel_ir : obp_pkg::tap_cap_dr;
      obp_pkg::tap_cap_dr: return m ? obp_pkg::tap_ex1_dr : obp_pkg::tap_sh_dr;
      obp_pkg::tap_sh_dr: return m ? obp_pkg::tap_ex1_dr : obp_pkg::tap_sh_dr;
      obp_pkg::tap_ex1_dr: return m ? obp_pkg::tap_upd_dr : obp_pkg::tap_pau_dr;
      obp_pkg::tap_pau_dr: return m ? obp_pkg::tap_ex2_dr : obp_pkg::tap_pau_dr;
      obp_pkg::tap_ex2_dr: return m ? obp_pkg::tap_upd_dr : obp_pkg::tap_sh_dr;
      obp_pkg::tap_sel_ir: return m ? obp_pkg::tap_tlr : obp_pkg::tap_cap_ir;
      obp_pkg::tap_cap_ir: return m ? obp_pkg::tap_ex1_ir : obp_pkg::tap_sh_ir;
      obp_pkg::tap_sh_ir: return m ? obp_pkg::tap_ex1_ir : obp_pkg::tap_sh_ir;
      obp_pkg::tap_ex1_ir: return m ? obp_pkg::tap_upd_ir : obp_pkg::tap_pau_ir;
      obp_pkg::tap_pau_ir: return m ? obp_pkg::tap_ex2_ir : obp_pkg::tap_pau_ir;
      obp_pkg::tap_ex2_ir: return m ? obp_pkg::tap_upd_ir : obp_pkg::tap_sh_ir;
      default: return m ? obp_pkg::tap_sel_dr : obp_pkg::tap_rti;
    endcase
  endfunction

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !pin_sync[3] || !tap_en) begin
      tap <= obp_pkg::tap_tlr;
    end else if (rise) begin
      tap <= next_tap(tap, pin_sync[1]);
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !pin_sync[3] || !tap_en) begin
      ir <= `OBP_IR_BYPASS;
      ir_sh <= '0;
      dr_sh <= '0;
      byp <= 1'b0;
    end else if (rise) begin
      case (tap)
        obp_pkg::tap_tlr: ir <= `OBP_IR_BYPASS;
        obp_pkg::tap_cap_ir: ir_sh <= `OBP_IR_CAPTURE;
        obp_pkg::tap_sh_ir: ir_sh <= {pin_sync[2], ir_sh[`OBP_IR_LEN-1:1]};
        obp_pkg::tap_upd_ir: ir <= ir_sh;
        obp_pkg::tap_cap_dr: begin
          byp <= 1'b0;
          if (ir == `OBP_IR_STATUS) begin
            dr_sh <= {3'h0, o_halt, i_pc};
          end else if (ir == `OBP_IR_PCREAD) begin
            dr_sh <= {4'h0, halt_pc};
          end else begin
            dr_sh <= '0;
          end
        end
        obp_pkg::tap_sh_dr: begin
          dr_sh <= {pin_sync[2], dr_sh[`OBP_DR_LEN-1:1]};
          byp <= pin_sync[2];
        end
        default: begin
        end
      endcase
    end
  end

  // data-out moves on the falling edge, and clears while the port is disabled
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !tap_en) begin
      tdo <= 1'b0;
    end else if (fall) begin
      if (tap == obp_pkg::tap_sh_ir) begin
        tdo <= ir_sh[0];
      end else if (ir == `OBP_IR_BYPASS) begin
        tdo <= byp;
      end else begin
        tdo <= dr_sh[0];
      end
    end
  end

  assign link.tdo = tdo;
  assign upd = rise && (tap == obp_pkg::tap_upd_dr) && tap_en;

  // --------------------------------------------------------------------------
  // debug unit
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      cmp_en <= '0;
      for (int i = 0; i < `OBP_NUM_CMP; i++) begin
        cmp_addr[i] <= '0;
      end
    end else if (upd && ir == `OBP_IR_CMPSET) begin
      cmp_addr[dr_sh[`OBP_CMP_IDX_HI:`OBP_CMP_IDX_LO]] <= dr_sh[`OBP_PC_W-1:0];
      cmp_en[dr_sh[`OBP_CMP_IDX_HI:`OBP_CMP_IDX_LO]] <= dr_sh[`OBP_CMP_EN_BIT];
    end
  end

  always_comb begin
    hit = i_break_fetch && `OBP_SW_BREAK_EN;
    for (int i = 0; i < `OBP_NUM_CMP; i++) begin
      if (cmp_en[i] && cmp_addr[i] == i_pc) begin
        hit = 1'b1;
      end
    end
  end

  // a new break in the start cycle wins over the start
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_halt <= 1'b0;
      halt_pc <= '0;
    end else if (hit && !o_halt) begin
      o_halt <= 1'b1;
      halt_pc <= i_pc;
    end else if (upd && ir == `OBP_IR_START && !hit) begin
      o_halt <= 1'b0;
    end
  end

endmodule

// File: sim/obp_link_properties.sv
// Purpose: timing relations on the probe-target link wires
// Assumes: inputs are the link signals seen in the i_clock domain
// Notes: tck half period is 8 clocks
`timescale 1ns/10ps
module obp_link_properties (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic trst_n,
  input wire logic srst_o,
  input wire logic srst_oe,
  input wire logic srst_n
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // ----
  // clock phases
  // ----
  sequence tck_high_span;
    tck [*8] ##1 !tck;
  endsequence
  sequence tck_low_span;
    !tck [*8] ##1 tck;
  endsequence
  a_tck_high_time: assert property ($rose(tck) |-> tck_high_span)
    else $error("tck high phase length wrong");
  a_tck_low_time: assert property ($fell(tck) |-> tck_low_span)
    else $error("tck low phase length wrong");
  // ----
  // wire timing
  // ----
  a_tms_on_low: assert property ($changed(tms) |-> !tck)
    else $error("tms moved while tck high");
  a_tdi_on_low: assert property ($changed(tdi) |-> !tck)
    else $error("tdi moved while tck high");
  a_tdo_on_low: assert property ($changed(tdo) |-> !tck)
    else $error("tdo moved while tck high");
  a_reset_tms_high: assert property ($rose(i_rst_n) |-> tms [*8])
    else $error("tms not high after reset");
  a_test_reset_hold: assert property ($rose(i_rst_n) |-> !trst_n [*8])
    else $error("test reset not held after reset");
  a_srst_low_only: assert property (srst_oe |-> !srst_o)
    else $error("system reset driven high");
endmodule

// File: sim/ocd_breakpoint_jtag_probe_tb.sv
// Purpose: drives probe user side and target core side across one link
// Assumes: single target on the chain
// Notes: port-disable and reset changes are aligned to tck low phases
`timescale 1ns/10ps
`include "obp_map.svh"
module ocd_breakpoint_jtag_probe_tb;
  logic i_clock;
  logic i_rst_n;
  logic i_cmd_valid;
  obp_pkg::obp_cmd_type i_cmd;
  logic [1:0] i_bp_index;
  logic [15:0] i_bp_addr;
  logic i_tap_reset;
  logic i_hold_reset;
  logic o_cmd_ready;
  logic o_stopped;
  logic o_state_valid;
  logic [15:0] o_state_pc;
  logic [15:0] i_pc;
  logic i_break_fetch;
  logic i_port_disable;
  logic o_halt;
  logic o_core_reset_n;
  int miscompares;
  int comparisons;
  logic [31:0] seed;
  obp_if link();
  obp_probe obp_probe_inst(.i_clock(i_clock), .i_rst_n(i_rst_n), .link(link),
    .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd), .i_bp_index(i_bp_index),
    .i_bp_addr(i_bp_addr), .i_tap_reset(i_tap_reset), .i_hold_reset(i_hold_reset),
    .o_cmd_ready(o_cmd_ready), .o_stopped(o_stopped), .o_state_valid(o_state_valid),
    .o_state_pc(o_state_pc));
  obp_target obp_target_inst(.i_clock(i_clock), .i_rst_n(i_rst_n), .link(link),
    .i_pc(i_pc), .i_break_fetch(i_break_fetch), .i_port_disable(i_port_disable),
    .o_halt(o_halt), .o_core_reset_n(o_core_reset_n));
  obp_link_properties obp_link_properties_inst(.i_clock(i_clock), .i_rst_n(i_rst_n),
    .tck(link.tck), .tms(link.tms), .tdi(link.tdi), .tdo(link.tdo), .trst_n(link.trst_n),
    .srst_o(link.srst_o), .srst_oe(link.srst_oe), .srst_n(link.srst_n));
  // ----
  // helpers
  // ----
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // slot 3 has no comparator behind it
  function automatic logic exp_break(input logic [1:0] idx);
    return idx != `OBP_USER_BAD_IDX;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // keeps target-side resets of tdo inside a tck low phase
  task automatic at_tck_fall;
    @(negedge link.tck);
    tick(1);
  endtask
  task automatic wait_for(input int which, input int limit);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < limit) begin
      @(negedge i_clock);
      n++;
      case (which)
        0: hit = (o_cmd_ready === 1'b1);
        1: hit = (o_state_valid === 1'b1);
        2: hit = (o_stopped === 1'b0);
        default: hit = (link.trst_n === 1'b0);
      endcase
    end
    check({15'h0, hit}, 16'h1);
  endtask
  task automatic send_cmd(input obp_pkg::obp_cmd_type cmd, input logic [1:0] idx,
                          input logic [15:0] addr);
    tick(1);
    i_cmd = cmd;
    i_bp_index = idx;
    i_bp_addr = addr;
    i_cmd_valid = 1'b1;
    wait_for(0, 3000);
    tick(1);
    i_cmd_valid = 1'b0;
  endtask
  task automatic resume;
    send_cmd(obp_pkg::cmd_start, 2'h0, 16'h0);
    wait_for(2, 1500);
    // probe ends the scan half a tck period before the target sees update
    tick(2 * `OBP_TCK_HALF_CYC + 4);
    check({15'h0, o_halt}, 16'h0);
  endtask
  task automatic hw_break(input logic [1:0] idx, input logic [15:0] addr);
    i_pc = addr ^ 16'h8000;
    send_cmd(obp_pkg::cmd_set_bp, idx, addr);
    tick(800);
    i_pc = addr;
    tick(6);
    check({15'h0, o_halt}, {15'h0, exp_break(idx)});
    if (exp_break(idx)) begin
      wait_for(1, 4000);
      check(o_state_pc, addr);
      check({15'h0, o_stopped}, 16'h1);
      i_pc = addr ^ 16'h8000;
      resume();
    end
    i_pc = addr ^ 16'h8000;
    send_cmd(obp_pkg::cmd_clr_bp, idx, addr);
    tick(800);
    i_pc = addr;
    tick(6);
    check({15'h0, o_halt}, 16'h0);
    i_pc = addr ^ 16'h8000;
    $display("test hw break slot %0d done", idx);
  endtask
  // ----
  // stimulus
  // ----
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end
  initial begin
    #600_000;
    miscompares++;
    conclude();
  end
  initial begin
    logic [15:0] n;
    i_rst_n = 1'b0;
    i_cmd_valid = 1'b0;
    i_cmd = obp_pkg::cmd_start;
    i_bp_index = 2'h0;
    i_bp_addr = 16'h0;
    i_tap_reset = 1'b0;
    i_hold_reset = 1'b0;
    i_pc = 16'h0;
    i_break_fetch = 1'b0;
    i_port_disable = 1'b0;
    miscompares = 0;
    comparisons = 0;
    seed = 32'h8D9530B5;
    tick(5);
    i_rst_n = 1'b1;
    // the rising clock itself is the first high sample
    n = 16'h1;
    @(posedge link.tck);
    tick(1);
    while (link.tck === 1'b1 && n < 16'h40) begin
      tick(1);
      n++;
    end
    check(n, 16'(`OBP_TCK_HALF_CYC));
    $display("test tck period done");
    for (int k = 0; k < 4; k++) begin
      seed = next_rand(seed);
      hw_break(k[1:0], (k == 0) ? 16'hFFFF : seed[15:0]);
    end
    seed = next_rand(seed);
    i_pc = seed[15:0];
    i_break_fetch = 1'b1;
    tick(1);
    i_break_fetch = 1'b0;
    wait_for(1, 4000);
    check(o_state_pc, seed[15:0]);
    tick(2000);
    check({15'h0, o_halt}, 16'h1);
    check({15'h0, o_stopped}, 16'h1);
    resume();
    $display("test sw break done");
    at_tck_fall();
    i_port_disable = 1'b1;
    i_hold_reset = 1'b1;
    tick(20);
    check({15'h0, link.srst_n}, 16'h0);
    check({15'h0, o_core_reset_n}, 16'h0);
    at_tck_fall();
    i_hold_reset = 1'b0;
    tick(20);
    check({15'h0, link.srst_n}, 16'h1);
    check({15'h0, o_core_reset_n}, 16'h1);
    at_tck_fall();
    i_port_disable = 1'b0;
    i_tap_reset = 1'b1;
    wait_for(3, 400);
    at_tck_fall();
    i_tap_reset = 1'b0;
    tick(200);
    $display("test resets done");
    seed = next_rand(seed);
    hw_break(2'h1, seed[15:0]);
    conclude();
  end
endmodule
